// ==== rtl/ctsq_trap_map.vh ====
`ifndef CTSQ_TRAP_MAP_VH
`define CTSQ_TRAP_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTSQ_OFS_CTRL   12'h000
`define CTSQ_OFS_STAT   12'h004
`define CTSQ_OFS_SAVE   12'h008
`define CTSQ_CTRL_RST   9'h000

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTSQ_C_TRAP     0
`define CTSQ_C_PAR      1
`define CTSQ_C_PROT     2
`define CTSQ_C_CHAN     3
`define CTSQ_C_MHI      8
`define CTSQ_C_MLO      4

// ----------------------------------------
// Trap indices, highest priority first
// ----------------------------------------
`define CTSQ_T_BLAST    4'd0
`define CTSQ_T_VIOL     4'd1
`define CTSQ_T_PAR      4'd2
`define CTSQ_T_FP       4'd3
`define CTSQ_T_PRE      4'd4
`define CTSQ_T_OVF      4'd5
`define CTSQ_T_DD       4'd6
`define CTSQ_T_CHA      4'd7
`define CTSQ_NONE       5'h10

// ----------------------------------------
// Save and transfer addresses
// ----------------------------------------
`define CTSQ_A_BLAST    15'h0020
`define CTSQ_A_VIOL     15'h0022
`define CTSQ_A_PAR      15'h0024
`define CTSQ_A_FP       15'h0000
`define CTSQ_A_FPX      15'h0008
`define CTSQ_A_PRE      15'h001A
`define CTSQ_A_OVF      15'h0006
`define CTSQ_A_DD       15'h0014
`define CTSQ_A_CHA      15'h000A
`define CTSQ_BIT35      15'h0001

// ----------------------------------------
// Save word layout, bit n at index 35-n
// ----------------------------------------
`define CTSQ_W_S        35
`define CTSQ_W_B14      21
`define CTSQ_W_B17      18
`define CTSQ_W_DHI      32
`define CTSQ_W_DLO      18
`define CTSQ_W_AHI      14

// ----------------------------------------
// Timing
// ----------------------------------------
`define CTSQ_BLAST_MS   33
`define CTSQ_CLK_KHZ    50000

`endif

// ==== rtl/ctsq_trap_sequencer.v ====
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ctsq_trap_map.vh"

module ctsq_trap_sequencer #(
    parameter [20:0] BLAST_SPAN = `CTSQ_BLAST_MS * `CTSQ_CLK_KHZ
) (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        endOp,
    input  wire        tA4,
    input  wire        tA4D2,
    input  wire        tA45,
    input  wire        tI1,
    input  wire        tI3,
    input  wire        tI5,
    input  wire        tE0,
    input  wire        tE5,
    input  wire        itStep,
    input  wire        itOverflow,
    input  wire        parityErr,
    input  wire        fpErr,
    input  wire        mpViolation,
    input  wire        ddReq,
    input  wire [4:0]  chanReq,
    input  wire        selectInstr,
    input  wire        maskLoadInstr,
    input  wire        restoreChanInstr,
    input  wire        inhibitChanInstr,
    input  wire        setProtectInstr,
    input  wire        runOutInstr,
    input  wire        resetLoadChanInstr,
    input  wire [14:0] icIn,
    input  wire [14:0] addrIn,
    output reg         trapTrig,
    output reg         blockIcStep,
    output reg         blastCtl,
    output reg         forceEndOp,
    output reg         progRegReset,
    output reg         addrLoad,
    output reg  [14:0] addrOut,
    output reg         memAddrLoad,
    output reg  [14:0] memAddr,
    output reg         storeWrite,
    output reg  [35:0] storeData,
    output reg         icLoad,
    output reg  [14:0] icValue
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_TI   = 3'b010;
    localparam [2:0] ST_TE   = 3'b100;

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Lowest set index wins; bit 4 set means none
    function [4:0] ctsqPick;
        input [11:0] v;
        integer i;
        begin
            ctsqPick = `CTSQ_NONE;
            for (i = 11; i >= 0; i = i - 1) begin
                if (v[i])
                    ctsqPick = {1'b0, i[3:0]};
            end
        end
    endfunction

    // Save address of each trap
    function [14:0] ctsqSave;
        input [3:0] t;
        reg   [3:0] k;
        begin
            k = t - `CTSQ_T_CHA;
            case (t)
                `CTSQ_T_BLAST: ctsqSave = `CTSQ_A_BLAST;
                `CTSQ_T_VIOL:  ctsqSave = `CTSQ_A_VIOL;
                `CTSQ_T_PAR:   ctsqSave = `CTSQ_A_PAR;
                `CTSQ_T_FP:    ctsqSave = `CTSQ_A_FP;
                `CTSQ_T_PRE:   ctsqSave = `CTSQ_A_PRE;
                `CTSQ_T_OVF:   ctsqSave = `CTSQ_A_OVF;
                `CTSQ_T_DD:    ctsqSave = `CTSQ_A_DD;
                default:       ctsqSave = `CTSQ_A_CHA + {10'h000, k, 1'b0};
            endcase
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [2:0]  state_reg;
    reg [3:0]  cur_reg;
    reg [11:0] pend_reg;
    reg [8:0]  ctrl_reg;
    reg        stacked_reg;
    reg        selHold_reg;
    reg        xferPend_reg;
    reg        sFlag_reg;
    reg [14:0] savedIc_reg;
    reg [14:0] parAddr_reg;
    reg [14:0] lastSave_reg;
    reg [20:0] itIdle_reg;
    reg [11:0] hv;
    reg [35:0] word;
    reg [31:0] rdMux;

    // ----------------------------------------
    // Enables and qualifiers
    // ----------------------------------------
    wire        idle      = (state_reg == ST_IDLE);
    wire        trapEn    = ctrl_reg[`CTSQ_C_TRAP];
    wire        parEn     = trapEn & ctrl_reg[`CTSQ_C_PAR];
    wire        protOn    = ctrl_reg[`CTSQ_C_PROT];
    wire        chanEn    = ctrl_reg[`CTSQ_C_CHAN];
    wire        chainNow  = (state_reg == ST_TE) & tE5 & (cur_reg == `CTSQ_T_PRE);
    wire        protGate  = protOn & ~chainNow;
    wire        privInstr = selectInstr | maskLoadInstr | restoreChanInstr |
                            inhibitChanInstr | setProtectInstr | runOutInstr;
    wire        defer     = privInstr & ~chainNow;
    wire        hold      = (selHold_reg | selectInstr) & ~chainNow;
    wire        lowOk     = trapEn & ~defer & ~hold;
    wire [4:0]  chanLive  = pend_reg[`CTSQ_T_CHA +: 5] & ctrl_reg[`CTSQ_C_MHI:`CTSQ_C_MLO];

    always @* begin
        hv = 12'h000;
        hv[`CTSQ_T_BLAST] = pend_reg[`CTSQ_T_BLAST];
        hv[`CTSQ_T_VIOL]  = pend_reg[`CTSQ_T_VIOL] & ~hold;
        hv[`CTSQ_T_PAR]   = pend_reg[`CTSQ_T_PAR] & parEn & ~hold;
        hv[`CTSQ_T_FP]    = pend_reg[`CTSQ_T_FP] & ~hold;
        hv[`CTSQ_T_PRE]   = protGate & lowOk &
                            (pend_reg[`CTSQ_T_OVF] | (chanEn & (|chanLive)));
        hv[`CTSQ_T_OVF]   = pend_reg[`CTSQ_T_OVF] & lowOk & ~protGate;
        hv[`CTSQ_T_DD]    = pend_reg[`CTSQ_T_DD] & lowOk & chanEn & ~protGate;
        hv[`CTSQ_T_CHA +: 5] = chanLive & {5{lowOk & chanEn & ~protGate}};
    end

    wire [4:0]  pick     = ctsqPick(hv);
    wire        pickOk   = ~pick[4];
    wire [14:0] pickSave = ctsqSave(pick[3:0]);
    wire [14:0] curSave  = ctsqSave(cur_reg);
    wire        rec      = idle & ~xferPend_reg & (endOp | forceEndOp) & pickOk;
    wire        chainGo  = chainNow & pickOk;
    wire [11:0] clrv     = (rec | chainGo) ? (12'h001 << pick[3:0]) : 12'h000;

    // ----------------------------------------
    // Request latches
    // ----------------------------------------

    // idle span of the interval timer
    wire blastSet = ~itStep & (itIdle_reg == BLAST_SPAN - 21'd1);
    wire violSet  = (mpViolation & trapEn & protOn) | (endOp & setProtectInstr & protOn);
    wire [11:0] setv = {chanReq, ddReq, itOverflow, 1'b0, fpErr, parityErr, violSet, blastSet};
    // blast only for blast or live parity
    wire blastGo  = tA4 & idle & ~xferPend_reg & ~blastCtl &
                    (pend_reg[`CTSQ_T_BLAST] |
                     (pend_reg[`CTSQ_T_PAR] & parEn & ~stacked_reg));

    // Timer idle counter saturates so the request fires once
    always @(posedge ref_clk) begin
        if (sys_rst)
            itIdle_reg <= 21'h000000;
        else if (itStep)
            itIdle_reg <= 21'h000000;
        else if (itIdle_reg != BLAST_SPAN)
            itIdle_reg <= itIdle_reg + 21'd1;
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_reg    <= 12'h000;
            stacked_reg <= 1'b0;
            selHold_reg <= 1'b0;
        end else begin
            pend_reg    <= (pend_reg & ~clrv) | setv;
            stacked_reg <= (stacked_reg & ~clrv[`CTSQ_T_PAR]) |
                           (pend_reg[`CTSQ_T_PAR] & ~parEn);
            // hold from select to channel load
            if (endOp & resetLoadChanInstr)
                selHold_reg <= 1'b0;
            else if (endOp & selectInstr)
                selHold_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Control triggers
    // ----------------------------------------
    wire apbSetup = psel & ~penable;
    wire apbWr    = psel & penable & pready & pwrite;

    // Hardware actions follow the software write, so they win
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `CTSQ_CTRL_RST;
        end else begin
            if (apbWr & (paddr == `CTSQ_OFS_CTRL))
                ctrl_reg <= pwdata[8:0];
            if (endOp & idle) begin
                // outside protect mode it just sets it
                if (setProtectInstr & ~protOn)
                    ctrl_reg[`CTSQ_C_PROT] <= 1'b1;
                if (restoreChanInstr | maskLoadInstr)
                    ctrl_reg[`CTSQ_C_CHAN] <= 1'b1;
                if (inhibitChanInstr)
                    ctrl_reg[`CTSQ_C_CHAN] <= 1'b0;
            end
            if ((state_reg == ST_TE) & tE5) begin
                if (cur_reg == `CTSQ_T_PRE)
                    ctrl_reg[`CTSQ_C_PROT] <= 1'b0;
                if (cur_reg >= `CTSQ_T_CHA)
                    ctrl_reg[`CTSQ_C_CHAN] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Save word
    // ----------------------------------------

    always @* begin
        word = 36'h000000000;
        word[`CTSQ_W_AHI:0] = savedIc_reg;
        case (cur_reg)
            `CTSQ_T_FP: begin
                word[`CTSQ_W_B14] = 1'b1;
                word[`CTSQ_W_B17] = 1'b1;
            end
            `CTSQ_T_PAR: begin
                word[`CTSQ_W_DHI:`CTSQ_W_DLO] = parAddr_reg;
                word[`CTSQ_W_S] = sFlag_reg;
            end
            `CTSQ_T_BLAST, `CTSQ_T_VIOL, `CTSQ_T_OVF: begin
                word[`CTSQ_W_S] = 1'b0;
            end
            default: begin
                word[`CTSQ_W_B17] = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Trap sequencer
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            cur_reg      <= `CTSQ_T_BLAST;
            savedIc_reg  <= 15'h0000;
            parAddr_reg  <= 15'h0000;
            lastSave_reg <= 15'h0000;
            sFlag_reg    <= 1'b0;
            xferPend_reg <= 1'b0;
            trapTrig     <= 1'b0;
            blockIcStep  <= 1'b0;
            blastCtl     <= 1'b0;
            forceEndOp   <= 1'b0;
            progRegReset <= 1'b0;
            addrLoad     <= 1'b0;
            addrOut      <= 15'h0000;
            memAddrLoad  <= 1'b0;
            memAddr      <= 15'h0000;
            storeWrite   <= 1'b0;
            storeData    <= 36'h000000000;
            icLoad       <= 1'b0;
            icValue      <= 15'h0000;
        end else begin
            addrLoad     <= 1'b0;
            memAddrLoad  <= 1'b0;
            icLoad       <= 1'b0;
            progRegReset <= 1'b0;
            forceEndOp   <= 1'b0;
            if (blastGo)
                blastCtl <= 1'b1;
            if (idle & blastCtl & ~trapTrig) begin
                if (tA4D2)
                    progRegReset <= 1'b1;
                if (tA45)
                    forceEndOp <= 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    // trap trigger and step block at end-op
                    if (rec) begin
                        state_reg    <= ST_TI;
                        cur_reg      <= pick[3:0];
                        savedIc_reg  <= icIn;
                        parAddr_reg  <= addrIn;
                        sFlag_reg    <= stacked_reg;
                        lastSave_reg <= pickSave;
                        trapTrig     <= 1'b1;
                        blockIcStep  <= 1'b1;
                    end else if (xferPend_reg & tI1) begin
                        icLoad       <= 1'b1;
                        icValue      <= addrOut;
                        xferPend_reg <= 1'b0;
                        trapTrig     <= 1'b0;
                        blockIcStep  <= 1'b0;
                        blastCtl     <= 1'b0;
                    end
                end
                ST_TI: begin
                    if (tI3)
                        progRegReset <= 1'b1;
                    if (tI5) begin
                        addrLoad  <= 1'b1;
                        addrOut   <= curSave;
                        state_reg <= ST_TE;
                    end
                end
                ST_TE: begin
                    if (tE0) begin
                        memAddrLoad <= 1'b1;
                        memAddr     <= curSave;
                        storeData   <= word;
                        storeWrite  <= 1'b1;
                    end
                    if (tE5) begin
                        storeWrite <= 1'b0;
                        if (cur_reg == `CTSQ_T_FP) begin
                            icLoad      <= 1'b1;
                            icValue     <= `CTSQ_A_FPX;
                            trapTrig    <= 1'b0;
                            blockIcStep <= 1'b0;
                            blastCtl    <= 1'b0;
                            state_reg   <= ST_IDLE;
                        end else if (chainGo) begin
                            state_reg    <= ST_TI;
                            cur_reg      <= pick[3:0];
                            savedIc_reg  <= curSave | `CTSQ_BIT35;
                            lastSave_reg <= pickSave;
                            sFlag_reg    <= 1'b0;
                        end else begin
                            addrLoad     <= 1'b1;
                            addrOut      <= curSave | `CTSQ_BIT35;
                            xferPend_reg <= 1'b1;
                            state_reg    <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------

    // Read mux; status is sampled in the setup cycle
    always @* begin
        case (paddr)
            `CTSQ_OFS_CTRL: rdMux = {23'h000000, ctrl_reg};
            `CTSQ_OFS_STAT: rdMux = {12'h000, cur_reg, 1'b0, selHold_reg,
                                     ~idle | xferPend_reg, stacked_reg, pend_reg};
            `CTSQ_OFS_SAVE: rdMux = {17'h00000, lastSave_reg};
            default:        rdMux = 32'h00000000;
        endcase
    end

    wire mapped = (paddr == `CTSQ_OFS_CTRL) | (paddr == `CTSQ_OFS_STAT) |
                  (paddr == `CTSQ_OFS_SAVE);

    // One access cycle, no wait states
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready <= apbSetup;
            if (apbSetup) begin
                pslverr <= ~mapped;
                prdata  <= (mapped & ~pwrite) ? rdMux : 32'h00000000;
            end
        end
    end

endmodule

`default_nettype wire

// ==== test/ctsq_trap_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Trap sequencing checks
// ----------------------------------------
module ctsq_trap_monitor (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        endOp,
    input wire logic        tA4,
    input wire logic        tA4D2,
    input wire logic        tA45,
    input wire logic        tI1,
    input wire logic        tI3,
    input wire logic        tI5,
    input wire logic        tE0,
    input wire logic        tE5,
    input wire logic        trapTrig,
    input wire logic        blockIcStep,
    input wire logic        blastCtl,
    input wire logic        forceEndOp,
    input wire logic        progRegReset,
    input wire logic        addrLoad,
    input wire logic [14:0] addrOut,
    input wire logic        memAddrLoad,
    input wire logic [14:0] memAddr,
    input wire logic        storeWrite,
    input wire logic        icLoad
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Entry, stepping and blast timing
    trap_entry_a: assert property ($rose(trapTrig) |-> $past(endOp) || $past(forceEndOp))
        else $error("trap entered off end-operation");
    step_block_a: assert property (trapTrig == blockIcStep)
        else $error("counter step block differs from trap trigger");
    blast_set_a: assert property ($rose(blastCtl) |-> $past(tA4))
        else $error("blast control set off A4");
    force_end_a: assert property (tA45 && blastCtl && !trapTrig |=> forceEndOp)
        else $error("no forced end after A4.5");
    prog_reset_a: assert property (progRegReset |-> $past(tA4D2) || $past(tI3))
        else $error("program register reset off A4 D2 or I3");
    // Address register loads: save address at I5, plus one at E5
    addr_load_a: assert property (addrLoad |-> $past(tI5) || $past(tE5))
        else $error("address register loaded off I5 or E5");
    save_addr_a: assert property (addrLoad && $past(tI5) |-> !addrOut[0])
        else $error("save address loaded odd at I5");
    addr_plus_a: assert property (addrLoad && $past(tE5) |-> addrOut[0])
        else $error("transfer address lacks bit 35 at E5");
    // Store cycle framing
    store_start_a: assert property ($rose(storeWrite) |-> $past(tE0) && memAddrLoad)
        else $error("save word write not launched by E0");
    store_end_a: assert property ($fell(storeWrite) |-> $past(tE5))
        else $error("save word write not ended by E5");
    save_even_a: assert property (memAddrLoad |-> !memAddr[0] && trapTrig)
        else $error("save address odd or outside a trap");
    ic_load_a: assert property (icLoad |-> $past(tI1) || $past(tE5))
        else $error("counter loaded off I1 or E5");
    store_in_trap_a: assert property (storeWrite |-> trapTrig || $past(tE5))
        else $error("store outside trap E cycle");
    trap_seen_c: cover property ($fell(trapTrig));
    blast_seen_c: cover property (forceEndOp);
    store_seen_c: cover property ($fell(storeWrite));
endmodule

bind ctsq_trap_sequencer ctsq_trap_monitor mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .endOp(endOp), .tA4(tA4), .tA4D2(tA4D2),
    .tA45(tA45), .tI1(tI1), .tI3(tI3), .tI5(tI5), .tE0(tE0), .tE5(tE5),
    .trapTrig(trapTrig), .blockIcStep(blockIcStep), .blastCtl(blastCtl),
    .forceEndOp(forceEndOp), .progRegReset(progRegReset), .addrLoad(addrLoad),
    .addrOut(addrOut), .memAddrLoad(memAddrLoad), .memAddr(memAddr),
    .storeWrite(storeWrite), .icLoad(icLoad)
);
`default_nettype wire

// ==== test/ctsq_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Instruction sequencer and core storage
// ----------------------------------------
module ctsq_cpu_model (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        trapTrig,
    input wire logic [14:0] memAddr,
    input wire logic        storeWrite,
    input wire logic [35:0] storeData,
    input wire logic        icLoad,
    input wire logic [14:0] icValue,
    output logic            tI1,
    output logic            tI3,
    output logic            tI5,
    output logic            tE0,
    output logic            tE5,
    output logic [14:0]     lastIc
);
    logic [35:0] mem [0:63];
    logic [3:0]  phase;
    // Phase runs only in trap; wrap is next I cycle
    always @(posedge ref_clk) begin
        if (sys_rst || !trapTrig)
            phase <= 4'h0;
        else
            phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
        if (storeWrite)
            mem[memAddr[5:0]] <= storeData;
        if (icLoad)
            lastIc <= icValue;
    end
    assign tI3 = trapTrig && phase == 4'h2;
    assign tI5 = trapTrig && phase == 4'h4;
    assign tE0 = trapTrig && phase == 4'h6;
    assign tE5 = trapTrig && phase == 4'h9;
    assign tI1 = trapTrig && phase == 4'hB;
endmodule
`default_nettype wire

// ==== test/cpu_trap_sequencer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module cpu_trap_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, rd;
    logic        er, itStep = 1'b0, itRun = 1'b1;
    logic [8:0]  ev = 9'h000;
    logic [6:0]  ins = 7'h00;
    logic [4:0]  chanReq = 5'h00;
    logic [14:0] icIn = 15'h0123, addrIn = 15'h0456;
    wire  [31:0] prdata;
    wire         pready, pslverr, tI1, tI3, tI5, tE0, tE5, trapTrig, blastCtl;
    wire         storeWrite, icLoad;
    wire  [14:0] memAddr, icValue;
    wire  [35:0] storeData;
    int          fails = 0, total_checks = 0;

    ctsq_trap_sequencer #(.BLAST_SPAN(21'h14)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .endOp(ev[0]), .tA4(ev[4]), .tA4D2(ev[5]),
        .tA45(ev[6]), .tI1(tI1), .tI3(tI3), .tI5(tI5), .tE0(tE0), .tE5(tE5),
        .itStep(itStep), .itOverflow(ev[1]), .parityErr(ev[3]), .fpErr(ev[2]),
        .mpViolation(ev[7]), .ddReq(ev[8]), .chanReq(chanReq), .selectInstr(ins[0]),
        .maskLoadInstr(ins[1]), .restoreChanInstr(ins[2]), .inhibitChanInstr(ins[3]),
        .setProtectInstr(ins[4]), .runOutInstr(ins[5]), .resetLoadChanInstr(ins[6]),
        .icIn(icIn), .addrIn(addrIn), .trapTrig(trapTrig), .blockIcStep(),
        .blastCtl(blastCtl), .forceEndOp(), .progRegReset(), .addrLoad(), .addrOut(),
        .memAddrLoad(), .memAddr(memAddr), .storeWrite(storeWrite),
        .storeData(storeData), .icLoad(icLoad), .icValue(icValue)
    );
    ctsq_cpu_model cpu (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .trapTrig(trapTrig), .memAddr(memAddr),
        .storeWrite(storeWrite), .storeData(storeData), .icLoad(icLoad),
        .icValue(icValue), .tI1(tI1), .tI3(tI3), .tI5(tI5), .tE0(tE0), .tE5(tE5),
        .lastIc()
    );

    // Clock and a running timer keep the blast quiet
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) itStep <= itRun & ~itStep;

    task results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus cycle waits for the slave, whatever its speed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input int b);
        @(posedge ref_clk);
        ev[b] <= 1'b1;
        @(posedge ref_clk);
        ev[b] <= 1'b0;
    endtask
    task seq;
        do @(posedge ref_clk); while (trapTrig !== 1'b1);
        do @(posedge ref_clk); while (trapTrig !== 1'b0);
        repeat (3) @(posedge ref_clk);
    endtask
    task trap(input int b);
        pulse(b);
        pulse(0);
        seq;
    endtask
    // Held request must wait one more instruction
    task defer(input int k);
        pulse(1);
        ins[k] <= 1'b1;
        pulse(0);
        ins[k] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(36'(trapTrig), 36'h0);
        pulse(0);
        seq;
        chk(36'(cpu.lastIc), 36'h7);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(36'(rd), 36'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(36'(er), 36'h1);
        apb(1'b1, 12'h000, 32'h1);
        trap(1);
        chk(cpu.mem[6], {21'h0, icIn});
        chk(36'(cpu.lastIc), 36'h7);
        for (int k = 1; k < 6; k++)
            defer(k);
        pulse(1);
        ins[0] <= 1'b1;
        pulse(0);
        ins[0] <= 1'b0;
        pulse(0);
        pulse(0);
        repeat (3) @(posedge ref_clk);
        chk(36'(trapTrig), 36'h0);
        ins[6] <= 1'b1;
        pulse(0);
        ins[6] <= 1'b0;
        pulse(0);
        seq;
        chk(36'(cpu.lastIc), 36'h7);
        trap(2);
        chk(cpu.mem[0], 36'h000240123);
        chk(36'(cpu.lastIc), 36'h8);
        apb(1'b1, 12'h000, 32'h29);
        @(posedge ref_clk);
        chanReq <= 5'h02;
        @(posedge ref_clk);
        chanReq <= 5'h00;
        pulse(0);
        seq;
        chk(cpu.mem[12], 36'h000040123);
        chk(36'(cpu.lastIc), 36'hD);
        apb(1'b0, 12'h000, 32'h0);
        chk(36'(rd[3]), 36'h0);
        apb(1'b1, 12'h000, 32'h5);
        trap(1);
        chk(cpu.mem[26], 36'h000040123);
        chk(cpu.mem[6], 36'h00000001B);
        apb(1'b0, 12'h000, 32'h0);
        chk(36'(rd[2]), 36'h0);
        apb(1'b1, 12'h000, 32'h5);
        ins[4] <= 1'b1;
        pulse(0);
        ins[4] <= 1'b0;
        pulse(0);
        seq;
        chk(36'(cpu.lastIc), 36'h23);
        itRun <= 1'b0;
        repeat (30) @(posedge ref_clk);
        pulse(4);
        itRun <= 1'b1;
        @(posedge ref_clk);
        chk(36'(blastCtl), 36'h1);
        pulse(5);
        pulse(6);
        seq;
        chk(cpu.mem[32], {21'h0, icIn});
        apb(1'b1, 12'h000, 32'h0);
        pulse(3);
        apb(1'b0, 12'h004, 32'h0);
        chk(36'(rd[12]), 36'h1);
        // Enabling parity releases the stacked request with S flag
        apb(1'b1, 12'h000, 32'h3);
        pulse(0);
        seq;
        chk(cpu.mem[36], 36'h811580123);
        chk(36'(cpu.lastIc), 36'h25);
        results;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        results;
    end
endmodule
`default_nettype wire
